// File: rtl/ale_map.vh
// Address map and constants for the angle linearization engine.
// Assumes a 12-bit angle and a 6-bit coefficient word address.
`ifndef ALE_MAP_VH
`define ALE_MAP_VH
`define ALE_SEG_BASE   6'h00
`define ALE_AMP_BASE   6'h11
`define ALE_PH_BASE    6'h1C
`define ALE_OFS_ADDR   6'h27
`define ALE_LAST_ADDR  6'h27
`define ALE_NUM_HARM   4'hB
`define ALE_FIRST_HARM 4'h1
`define ALE_FSO_MAX    12'hFFF
`define ALE_FSO_ZERO   12'h000
`define ALE_SIN_SHIFT  7
`define ALE_FRAC_MSB   7
`define ALE_SEG_MSB    11
`define ALE_SEG_LSB    8
`endif

// File: rtl/ale_engine.v
// Angle linearization engine: segmented or harmonic correction of a 12-bit angle.
// Assumes angle, write and NVM read data come from logic on clk_i (no sync needed).
`timescale 1ns/100ps
`include "ale_map.vh"

// Function
// - Exactly one of two methods, segmented or harmonic, is applied, picked by mode_harm_i.
// - Segmented mode splits the input angle range into sixteen equal segments, neighbours sharing an endpoint.
// - Inside a segment the output is a straight line between the segment's two endpoints.
// - Harmonic mode sums correction terms of up to eleven harmonics.
// - One amplitude and one phase coefficient are held for every harmonic.
// - Harmonic mode takes the angle, then adds the offset, then builds the terms.
// - Each term is amplitude times sine of harmonic index times angle plus phase.
// - Coefficients are loaded from NVM after reset and may be overwritten one by one later.
// - The result is unsigned and spans zero to the full twelve-bit code.
module ale_engine (
	input  wire        clk_i,
	input  wire        arst_n_i,
	input  wire        ce_i,
	input  wire        mode_harm_i,
	input  wire [11:0] angle_i,
	input  wire        angle_vld_i,
	input  wire        coef_we_i,
	input  wire [5:0]  coef_addr_i,
	input  wire [11:0] coef_data_i,
	input  wire [11:0] nvm_rd_data_i,
	output reg         nvm_rd_o,
	output reg  [5:0]  nvm_addr_o,
	output reg         load_done_o,
	output reg         busy_o,
	output reg  [11:0] angle_result_register_o,
	output reg         result_vld_o
);

	localparam [5:0] ST_LOAD = 6'h01;
	localparam [5:0] ST_IDLE = 6'h02;
	localparam [5:0] ST_SEG  = 6'h04;
	localparam [5:0] ST_OFFS = 6'h08;
	localparam [5:0] ST_HARM = 6'h10;
	localparam [5:0] ST_DONE = 6'h20;

	// Coefficient word map, one 12-bit word per address:
	//   0x00..0x10  segment endpoints, seventeen points bounding sixteen segments
	//   0x11..0x1B  signed harmonic amplitudes for harmonics one to eleven
	//   0x1C..0x26  harmonic phases, a full 12-bit code being one turn
	//   0x27        angle offset added before the harmonic terms are built
	// Harmonics that are not wanted must be given amplitude zero; there is no
	// separate enable, which keeps the sequencer at a fixed eleven steps.
	// The conversion latency is therefore constant per method: two cycles for
	// segmented and fourteen for harmonic, independent of the coefficients.
	// Runtime writes go straight to the working copy and may land in the middle
	// of a running conversion; the terms already summed keep the old value.
	// The working copy is not reset: its content is only trusted once
	// load_done_o has risen after the last nonvolatile word has landed.

	// Quarter-wave sine, 6-bit phase, amplitude 127; coarse but enough for small corrections
	function signed [8:0] ale_sin;
		input [11:0] ph;
		reg   [3:0]  idx;
		reg   [7:0]  mag;
		begin
			// Index mirrored in the second and fourth quarter, sign from the top bit
			idx = ph[10] ? ~ph[9:6] : ph[9:6];
			case (idx)
				4'h0: mag = 8'h06;
				4'h1: mag = 8'h13;
				4'h2: mag = 8'h1F;
				4'h3: mag = 8'h2B;
				4'h4: mag = 8'h36;
				4'h5: mag = 8'h41;
				4'h6: mag = 8'h4C;
				4'h7: mag = 8'h55;
				4'h8: mag = 8'h5E;
				4'h9: mag = 8'h66;
				4'hA: mag = 8'h6D;
				4'hB: mag = 8'h73;
				4'hC: mag = 8'h78;
				4'hD: mag = 8'h7B;
				4'hE: mag = 8'h7E;
				default: mag = 8'h7F;
			endcase
			ale_sin = ph[11] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
		end
	endfunction

	reg  [11:0] coef_mem [0:39];
	reg  [5:0]  state_r;
	reg  [5:0]  ld_wa_r;
	reg         ld_pend_r;
	reg  [11:0] angle_r;
	reg  [3:0]  harm_r;
	reg  signed [15:0] acc_r;

	// Wide sums keep the carry visible; the top bit is dropped on purpose to wrap at one turn
	wire [12:0] ofs_sum = {1'b0, angle_r} + {1'b0, coef_mem[`ALE_OFS_ADDR]};
	wire [12:0] fin_sum = {1'b0, angle_r} + {1'b0, acc_r[11:0]};

	// Segment select from the top four angle bits, fraction from the rest
	// The fraction is the low eight angle bits, so each segment spans 256 codes
	wire [3:0]  seg_w  = angle_r[`ALE_SEG_MSB:`ALE_SEG_LSB];
	wire [5:0]  seg_a0 = `ALE_SEG_BASE + {2'b00, seg_w};
	wire [5:0]  seg_a1 = seg_a0 + 6'h01;
	wire [11:0] seg_p0 = coef_mem[seg_a0];
	wire [11:0] seg_p1 = coef_mem[seg_a1];
	wire signed [12:0] seg_diff = $signed({1'b0, seg_p1}) - $signed({1'b0, seg_p0});
	wire signed [21:0] seg_prod = seg_diff * $signed({1'b0, angle_r[`ALE_FRAC_MSB:0]});
	wire signed [14:0] seg_sum  = $signed({3'b000, seg_p0}) + $signed(seg_prod[21:8]);

	// Harmonic term for index harm_r; angle_r already carries the offset here
	// Harmonic n lives at its base address plus n minus one
	wire [5:0]  amp_a  = `ALE_AMP_BASE + {2'b00, harm_r} - 6'h01;
	wire [5:0]  ph_a   = `ALE_PH_BASE + {2'b00, harm_r} - 6'h01;
	wire [15:0] n_t    = harm_r * angle_r;
	wire [11:0] h_ph   = n_t[11:0] + coef_mem[ph_a];
	wire signed [20:0] h_prod = $signed(coef_mem[amp_a]) * ale_sin(h_ph);
	wire signed [20:0] h_term = h_prod >>> `ALE_SIN_SHIFT;

	// Coefficient memory: NVM load first, runtime single writes afterwards
	always @(posedge clk_i) begin
		if (ce_i) begin
			if (ld_pend_r)
				coef_mem[ld_wa_r] <= nvm_rd_data_i;
			else if (coef_we_i && state_r != ST_LOAD && coef_addr_i <= `ALE_LAST_ADDR)
				coef_mem[coef_addr_i] <= coef_data_i;
		end
	end

	// Load timing: the strobe runs for forty back-to-back cycles, one address each.
	// Read data arrives one cycle after its strobe, so the write address is the
	// strobe address delayed by one; ld_pend_r marks that a word is in flight.
	// Runtime writes are refused until the load has finished, otherwise a late
	// nonvolatile word could overwrite a value software has just written.

	// Sequencer: load, then one conversion per accepted angle
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r                 <= ST_LOAD;
			nvm_rd_o                <= 1'b0;
			nvm_addr_o              <= 6'h00;
			ld_wa_r                 <= 6'h00;
			ld_pend_r               <= 1'b0;
			load_done_o             <= 1'b0;
			busy_o                  <= 1'b1;
			angle_r                 <= 12'h000;
			harm_r                  <= 4'h0;
			acc_r                   <= 16'h0000;
			angle_result_register_o <= 12'h000;
			result_vld_o            <= 1'b0;
		end else if (ce_i) begin
			result_vld_o <= 1'b0;
			ld_pend_r    <= nvm_rd_o; // Data returns one cycle after the read strobe
			ld_wa_r      <= nvm_addr_o;
			case (state_r)
				ST_LOAD: begin
					// Strobe each address once; finish after the last word lands
					if (!nvm_rd_o && !ld_pend_r && !load_done_o) begin
						nvm_rd_o <= 1'b1;
					end else if (nvm_rd_o) begin
						if (nvm_addr_o == `ALE_LAST_ADDR)
							nvm_rd_o <= 1'b0;
						else
							nvm_addr_o <= nvm_addr_o + 6'h01;
					end else if (ld_pend_r) begin
						load_done_o <= 1'b1;
						busy_o      <= 1'b0;
						state_r     <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					// Angle and method captured together; a later mode change waits
					if (angle_vld_i) begin
						angle_r <= angle_i;
						busy_o  <= 1'b1;
						state_r <= mode_harm_i ? ST_OFFS : ST_SEG;
					end
				end
				ST_SEG: begin
					// Clamp keeps the line inside the unsigned output span
					if (seg_sum < 0)
						angle_result_register_o <= `ALE_FSO_ZERO;
					else if (seg_sum > $signed({3'b000, `ALE_FSO_MAX}))
						angle_result_register_o <= `ALE_FSO_MAX;
					else
						angle_result_register_o <= seg_sum[11:0];
					result_vld_o <= 1'b1;
					busy_o       <= 1'b0;
					state_r      <= ST_IDLE;
				end
				ST_OFFS: begin
					// Offset applied before any term is built
					angle_r <= ofs_sum[11:0];
					acc_r   <= 16'h0000;
					harm_r  <= `ALE_FIRST_HARM;
					state_r <= ST_HARM;
				end
				ST_HARM: begin
					// One harmonic per cycle; a single multiplier is shared by all
					acc_r <= acc_r + h_term[15:0];
					if (harm_r == `ALE_NUM_HARM)
						state_r <= ST_DONE;
					else
						harm_r <= harm_r + 4'h1;
				end
				ST_DONE: begin
					// 12-bit add wraps naturally at one full turn
					angle_result_register_o <= fin_sum[11:0];
					result_vld_o <= 1'b1;
					busy_o       <= 1'b0;
					state_r      <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // ale_engine

// File: verification/ale_nvm_model.sv
// NVM model: identity segment table, zero harmonics and offset.
// Assumes the engine samples read data one clock after its strobe.
`timescale 1ns/100ps
module ale_nvm_model (
	input  wire        clk_i,
	input  wire        rd_i,
	input  wire [5:0]  addr_i,
	output reg  [11:0] data_o
);
	// Idle cycles show the inverse, so a late sample is caught
	always @(posedge clk_i) begin
		if (rd_i)
			data_o <= (addr_i < 6'h10) ? {addr_i[3:0], 8'h00} : {12{addr_i == 6'h10}};
		else
			data_o <= ~data_o;
	end
endmodule // ale_nvm_model

// File: verification/ale_engine_properties.sv
// Checker on the engine ports: load order, latencies, result pulse.
// Assumes ce_i stays high during loads and conversions.
`timescale 1ns/100ps
module ale_engine_properties (
	input wire        clk_i,
	input wire        arst_n_i,
	input wire        ce_i,
	input wire        mode_harm_i,
	input wire        angle_vld_i,
	input wire        nvm_rd_o,
	input wire [5:0]  nvm_addr_o,
	input wire        load_done_o,
	input wire        busy_o,
	input wire [11:0] angle_result_register_o,
	input wire        result_vld_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// Accepted angle for one method
	sequence s_take(m);
		ce_i && angle_vld_i && !busy_o && mode_harm_i == m;
	endsequence
	a_seg_latency: assert property (s_take(1'b0) ##1 ce_i |=> result_vld_o)
		else $error("segmented result late");
	a_harm_latency: assert property (s_take(1'b1) ##1 ce_i[*8] ##1 ce_i[*5] |=> result_vld_o)
		else $error("harmonic result late");
	a_harm_not_early: assert property (s_take(1'b1) ##1 ce_i |=> !result_vld_o)
		else $error("harmonic took segmented path");
	a_vld_pulse: assert property (result_vld_o |=> !result_vld_o)
		else $error("result pulse too long");
	a_result_hold: assert property (!result_vld_o |-> $stable(angle_result_register_o))
		else $error("result moved without pulse");
	a_load_step: assert property (ce_i && nvm_rd_o && nvm_addr_o != 6'h27
		|=> nvm_rd_o && nvm_addr_o == $past(nvm_addr_o) + 6'h01)
		else $error("load address skipped");
	a_load_done: assert property (ce_i && nvm_rd_o && nvm_addr_o == 6'h27 ##1 ce_i
		|=> load_done_o && !busy_o)
		else $error("load done late");
	a_done_sticky: assert property (load_done_o |=> load_done_o)
		else $error("load done dropped");
endmodule // ale_engine_properties
bind ale_engine ale_engine_properties u_ale_engine_properties (.*);

// File: verification/ale_engine_test.sv
// Bench: segmented and harmonic results against a reference model.
// Assumes the NVM model's identity table and a free clock enable.
`timescale 1ns/100ps
module ale_engine_test;
	reg         clk_i = 1'b0, arst_n_i = 1'b0, mode_harm_i = 1'b0;
	reg         angle_vld_i = 1'b0, coef_we_i = 1'b0;
	reg  [11:0] angle_i = 12'h000, coef_data_i = 12'h000, ofs = 12'h000;
	reg  [5:0]  coef_addr_i = 6'h00;
	wire [11:0] nvm_rd_data_i, angle_result_register_o;
	wire [5:0]  nvm_addr_o;
	wire        nvm_rd_o, load_done_o, busy_o, result_vld_o;
	reg  [11:0] p [0:16];
	reg  [11:0] exp_q [$];
	integer     fails = 0, comparisons = 0, cyc = 0, i, k, r, s;
	// Clock at 40 MHz
	initial forever #12.5 clk_i = ~clk_i;
	ale_engine u_ale_engine (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
		.mode_harm_i(mode_harm_i), .angle_i(angle_i), .angle_vld_i(angle_vld_i),
		.coef_we_i(coef_we_i), .coef_addr_i(coef_addr_i), .coef_data_i(coef_data_i),
		.nvm_rd_data_i(nvm_rd_data_i), .nvm_rd_o(nvm_rd_o), .nvm_addr_o(nvm_addr_o),
		.load_done_o(load_done_o), .busy_o(busy_o),
		.angle_result_register_o(angle_result_register_o), .result_vld_o(result_vld_o));
	ale_nvm_model u_ale_nvm_model (.clk_i(clk_i), .rd_i(nvm_rd_o), .addr_i(nvm_addr_o),
		.data_o(nvm_rd_data_i));
	task chk(input [11:0] seen, input [11:0] want);
		begin
			comparisons = comparisons + 1;
			if (seen !== want) begin
				fails = fails + 1;
				$display("wrong value at %0t: got %h want %h", $time, seen, want);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("comparisons %0d fails %0d", comparisons, fails);
			if (fails == 0 && comparisons > 0) $display("STATUS OK");
			else $display("STATUS NOT OK");
			$finish;
		end
	endtask
	task wr(input [5:0] a, input [11:0] v);
		begin
			@(negedge clk_i);
			{coef_we_i, coef_addr_i, coef_data_i} = {1'b1, a, v};
			@(negedge clk_i);
			coef_we_i = 1'b0;
		end
	endtask
	// Second angle lands while busy and must be ignored
	task conv(input m, input [11:0] a, input [11:0] e);
		begin
			@(negedge clk_i);
			{mode_harm_i, angle_i, angle_vld_i} = {m, a, 1'b1};
			exp_q.push_back(e);
			@(negedge clk_i);
			angle_i = ~a;
			@(negedge clk_i);
			angle_vld_i = 1'b0;
			for (i = 0; i < 40 && busy_o !== 1'b0; i = i + 1) @(negedge clk_i);
		end
	endtask
	// Straight line between the two endpoints of the angle's segment, clamped
	function [11:0] seg_exp(input [11:0] a);
		integer d;
		begin
			d = p[a[11:8] + 5'h01];
			d = (d - p[a[11:8]]) * a[7:0];
			d = d >>> 8;
			d = d + p[a[11:8]];
			seg_exp = (d < 0) ? 12'h000 : (d > 4095) ? 12'hFFF : d[11:0];
		end
	endfunction
	// Results checked against the oldest note; hang guard
	always @(negedge clk_i) begin
		cyc = cyc + 1;
		if (result_vld_o === 1'b1)
			chk(angle_result_register_o, exp_q.size() ? exp_q.pop_front() : ~angle_result_register_o);
		if (cyc == 3000) begin
			fails = fails + 1;
			wrap_up;
		end
	end
	initial begin
		r = $urandom(32'h401DB9B9);
		for (k = 0; k < 17; k = k + 1) p[k] = (k < 16) ? {k[3:0], 8'h00} : 12'hFFF;
		repeat (12) @(negedge clk_i);
		arst_n_i = 1'b1;
		for (i = 0; i < 100 && load_done_o !== 1'b1; i = i + 1) @(negedge clk_i);
		conv(1'b0, 12'hFFF, seg_exp(12'hFFF));
		for (k = 0; k < 16; k = k + 1)
			conv(1'b0, {k[3:0], 8'h00}, p[k]);
		for (k = 0; k < 24; k = k + 1) begin
			if (k % 4 == 3) begin
				s = $urandom % 17;
				r = $urandom;
				p[s] = r[11:0];
				wr(s[5:0], r[11:0]);
			end
			r = $urandom;
			conv(1'b0, r[11:0], seg_exp(r[11:0]));
		end
		for (k = 0; k < 8; k = k + 1) begin
			r = $urandom;
			if (k == 3) begin
				ofs = r[23:12];
				wr(6'h27, ofs);
			end
			conv(1'b1, r[11:0], r[11:0] + ofs);
		end
		wr(6'h11, 12'h080);
		conv(1'b1, 12'h400 - ofs, 12'h47F);
		conv(1'b1, 12'hC00 - ofs, 12'hB81);
		repeat (4) @(negedge clk_i);
		chk(12'(exp_q.size()), 12'h000);
		wrap_up;
	end
endmodule // ale_engine_test
